/* tb_wfi_wake_id_regs.sv */
/*
  Self-checking bench for the wake identifier bank: register table, reset,
  abort, extra clocks and identifier matching in both formats.
  Assumes the host model on the serial pins and mask bit 1 as don't-care.
*/
module tb_wfi_wake_id_regs
  import wfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================
  // signals
  localparam logic [28:0] ID_EXT = 29'h12345678;
  localparam logic [28:0] ID_STD = {11'h5A3, 18'h2AAAA};
  logic        ref_clk_i     = 1'b0;
  logic        sys_rst_i     = 1'b1;
  logic        frame_valid_i = 1'b0;
  logic        frame_ext_i   = 1'b0;
  logic [28:0] frame_id_i    = 29'h00000000;
  logic        spi_sclk_i;
  logic        spi_cs_n_i;
  logic        spi_mosi_i;
  logic        spi_miso_o;
  logic        spi_miso_oe_o;
  logic        id_match_o;
  logic        ident_format_select_o;
  logic [7:0]  rd;
  int          err_total = 0;
  int          compares  = 0;
  // address, written byte, byte read back
  logic [23:0] rows [20] = '{24'h30A5A5, 24'h305A5A, 24'h31A5A5, 24'h315A5A, 24'h32A5A5,
    24'h325A5A, 24'h33A5A4, 24'h335A58, 24'h34A501, 24'h345A02, 24'h35A5A5, 24'h355A5A,
    24'h36A5A5, 24'h365A5A, 24'h37A5A5, 24'h375A5A, 24'h38A5A0, 24'h385A40, 24'h7FA500,
    24'h005A00};

  // free-running 25 MHz clock
  always #20 ref_clk_i = ~ref_clk_i;

  // ==========================
  // instances
  wfi_wake_id_regs uut
  (
    .ref_clk_i             (ref_clk_i),
    .sys_rst_i             (sys_rst_i),
    .spi_sclk_i            (spi_sclk_i),
    .spi_cs_n_i            (spi_cs_n_i),
    .spi_mosi_i            (spi_mosi_i),
    .spi_miso_o            (spi_miso_o),
    .spi_miso_oe_o         (spi_miso_oe_o),
    .frame_valid_i         (frame_valid_i),
    .frame_ext_i           (frame_ext_i),
    .frame_id_i            (frame_id_i),
    .id_match_o            (id_match_o),
    .ident_format_select_o (ident_format_select_o)
  );

  wfi_host_model u_host
  (
    .ref_clk_i (ref_clk_i),
    .miso_i    (spi_miso_o),
    .miso_oe_i (spi_miso_oe_o),
    .sclk_o    (spi_sclk_i),
    .cs_n_o    (spi_cs_n_i),
    .mosi_o    (spi_mosi_i)
  );

  // ==========================
  // tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(a, 1'b1, d, 16, rd);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    u_host.xfer(a, 1'b0, 8'h00, 16, rd);
    check("register", exp, rd);
  endtask

  // release reset after six edges, then every register must read zero
  task automatic reset_check();
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (logic [6:0] a = 7'h30; a <= 7'h38; a++)
      rd_chk(a, WFI_RESET_BYTE);
    check("format select", 8'h00, {7'h00, ident_format_select_o});
  endtask

  task automatic cfg(input logic [28:0] id, input logic [28:0] m, input logic ext);
    wr(WFI_ADDR_W_EXT_ID_HIGH, id[17:10]);
    wr(WFI_ADDR_W_EXT_ID_MID, id[9:2]);
    wr(WFI_ADDR_W_ID_FORMAT_TOP, {id[1:0], ext, id[28:24]});
    wr(WFI_ADDR_W_BASE_ID_LOW, {id[23:18], 2'h0});
    wr(WFI_ADDR_W_EXT_MASK_TOP, {6'h00, m[17:16]});
    wr(WFI_ADDR_W_EXT_MASK_MID, m[15:8]);
    wr(WFI_ADDR_W_EXT_MASK_LOW, m[7:0]);
    wr(WFI_ADDR_W_BASE_MASK_HIGH, m[28:21]);
    wr(WFI_ADDR_W_BASE_MASK_DLC, {m[20:18], 5'h00});
    check("format select", {7'h00, ext}, {7'h00, ident_format_select_o});
  endtask

  // one-cycle frame; the answer is looked at in the cycle after it
  task automatic frame(input logic ext, input logic [28:0] id, input logic exp);
    @(posedge ref_clk_i);
    frame_valid_i <= 1'b1;
    frame_ext_i   <= ext;
    frame_id_i    <= id;
    @(posedge ref_clk_i);
    frame_valid_i <= 1'b0;
    frame_id_i    <= ~id;
    @(negedge ref_clk_i);
    check("match", {7'h00, exp}, {7'h00, id_match_o});
  endtask

  task automatic final_report();
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================
  // main sequence
  initial
  begin
    reset_check();
    for (int i = 0; i < 20; i++)
    begin
      wr(rows[i][22:16], rows[i][15:8]);
      rd_chk(rows[i][22:16], rows[i][7:0]);
    end
    // aborted write leaves the byte alone; clocks past 16 add no write
    u_host.xfer(WFI_ADDR_W_EXT_MASK_LOW, 1'b1, 8'hC3, 12, rd);
    rd_chk(WFI_ADDR_W_EXT_MASK_LOW, 8'h5A);
    u_host.xfer(WFI_ADDR_W_EXT_MASK_MID, 1'b1, 8'h3C, 24, rd);
    rd_chk(WFI_ADDR_W_EXT_MASK_MID, 8'h3C);
    // extended format: every identifier bit counts unless masked
    cfg(ID_EXT, 29'h00000000, 1'b1);
    frame(1'b1, ID_EXT, 1'b1);
    frame(1'b0, ID_EXT, 1'b0);
    for (int b = 0; b < 29; b++)
      frame(1'b1, ID_EXT ^ (29'h00000001 << b), 1'b0);
    cfg(ID_EXT, 29'h1FFFFFFF, 1'b1);
    for (int b = 0; b < 29; b++)
      frame(1'b1, ID_EXT ^ (29'h00000001 << b), 1'b1);
    // standard format: only the base bits take part
    cfg(ID_STD, 29'h00000000, 1'b0);
    frame(1'b0, 29'h000005A3, 1'b1);
    frame(1'b0, {18'h15555, 11'h5A3}, 1'b1);
    frame(1'b1, ID_STD, 1'b0);
    for (int b = 0; b < 11; b++)
      frame(1'b0, 29'h000005A3 ^ (29'h00000001 << b), 1'b0);
    // second reset in mid-run
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    reset_check();
    final_report();
  end
endmodule

/* wfi_host_model.sv */
/*
  Host model: mode 0 serial master for the register pins.
  Assumes one transfer at a time, called from the bench on ref_clk_i.
*/
module wfi_host_model
(
  input  wire logic ref_clk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // half period in clocks, above the four the synchronisers need
  localparam int PHASE = 5;

  // idle: clock low and still, deselected
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // n rising edges: below 16 aborts, above 16 clocks in zeros
  task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdat,
                      input int n, output logic [7:0] rdat);
    logic [23:0] bits;
    bits = {addr, wr, wdat, 8'h00};
    rdat = 8'h00;
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      mosi_o <= bits[23 - i];
      repeat (PHASE) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      if (i >= 8 && i < 16)
        rdat = {rdat[6:0], miso_oe_i ? miso_i : 1'bx};
      repeat (PHASE) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (PHASE) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // no pull on the line, so never leave the last bit standing
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule

/* wfi_id_matcher.sv */
/*
  Compares a received frame identifier with the programmed identifier and mask.
  Assumes the frame fields come from logic on ref_clk_i and are held for the
  cycle in which frame_valid_i is high.
*/
module wfi_id_matcher
  import wfi_pkg::*;
#(
  parameter bit MASK_DONT_CARE = 1'b1
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        frame_valid_i,
  input  wire logic        frame_ext_i,
  input  wire logic [28:0] frame_id_i,
  output logic             match_o,
  wfi_reg_if.match         cfg
);
  import wfi_pkg::*;

  logic [28:0] aligned_id;
  logic [28:0] bit_ok;
  logic        match_reg;

  // a standard identifier lives in the top eleven bits of the stored layout
  assign aligned_id = frame_ext_i ? frame_id_i
                                  : {frame_id_i[10:0], 18'h00000};

  // ==========================================================================
  // per-bit compare; a mask bit of the chosen polarity makes the bit a don't-care
  for (genvar i = 0; i < WFI_ID_W; i++)
  begin : g_bit
    logic in_scope;
    assign in_scope  = cfg.ext_sel || (i >= (WFI_ID_W - WFI_STD_ID_W));
    assign bit_ok[i] = !in_scope || (cfg.mask[i] == MASK_DONT_CARE)
                       || (aligned_id[i] == cfg.ident[i]);
  end

  // ==========================================================================
  // one-cycle match pulse; the frame format must agree with the selected one
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      match_reg <= 1'b0;
    else
      match_reg <= frame_valid_i && (frame_ext_i == cfg.ext_sel) && (&bit_ok);
  end

  assign match_o = match_reg;

endmodule

/* wfi_pkg.sv */
/*
  Shared constants for the wake frame identifier filter: register offsets,
  field positions, reset values and serial frame sizes.
  Assumes the slave, bank and matcher files import it; nothing here is clocked.
*/
package wfi_pkg;

  // ==========================================================================
  // register offsets (7-bit serial address space)
  localparam logic [6:0] WFI_ADDR_W_EXT_ID_HIGH    = 7'h30;
  localparam logic [6:0] WFI_ADDR_W_EXT_ID_MID     = 7'h31;
  localparam logic [6:0] WFI_ADDR_W_ID_FORMAT_TOP  = 7'h32;
  localparam logic [6:0] WFI_ADDR_W_BASE_ID_LOW    = 7'h33;
  localparam logic [6:0] WFI_ADDR_W_EXT_MASK_TOP   = 7'h34;
  localparam logic [6:0] WFI_ADDR_W_EXT_MASK_MID   = 7'h35;
  localparam logic [6:0] WFI_ADDR_W_EXT_MASK_LOW   = 7'h36;
  localparam logic [6:0] WFI_ADDR_W_BASE_MASK_HIGH = 7'h37;
  localparam logic [6:0] WFI_ADDR_W_BASE_MASK_DLC  = 7'h38;

  // ==========================================================================
  // field positions inside the byte registers
  localparam int unsigned WFI_FMT_BIT         = 5;
  localparam int unsigned WFI_EXT_IDENT_BITS_1_0_LSB  = 6;
  localparam int unsigned WFI_BASE_LOWER_LSB  = 2;
  localparam int unsigned WFI_BASE_MASK_L_LSB = 5;

  // ==========================================================================
  // reset values
  localparam logic [7:0] WFI_RESET_BYTE = 8'h00;
  localparam logic [7:0] WFI_READ_ZERO  = 8'h00;

  // ==========================================================================
  // identifier widths; serial frame: one address byte (7 address bits, write flag last), one data byte
  localparam int unsigned WFI_ID_W          = 29;
  localparam int unsigned WFI_STD_ID_W      = 11;
  localparam logic [4:0]  WFI_ADDR_DONE_CNT = 5'h07;
  localparam logic [4:0]  WFI_OUT_FIRST_CNT = 5'h09;
  localparam logic [4:0]  WFI_FRAME_LAST    = 5'h0F;

endpackage

/* wfi_reg_if.sv */
/*
  Carrier between the serial slave, the register bank and the matcher.
  Assumes one clock domain; all signals are synchronous to ref_clk_i.
*/
interface wfi_reg_if;

  logic [6:0]  addr;
  logic        wr_stb;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [28:0] ident;
  logic [28:0] mask;
  logic        ext_sel;

  modport spi   (output addr, output wr_stb, output wdata, input rdata);
  modport bank  (input addr, input wr_stb, input wdata, output rdata,
                 output ident, output mask, output ext_sel);
  modport match (input ident, input mask, input ext_sel);

endinterface

/* wfi_spi_slave.sv */
/*
  Serial register slave, mode 0, 16 clocks per access: 7 address bits and a
  write flag, then one data byte. Pins are synchronised into ref_clk_i, so the
  serial clock must stay below about one eighth of ref_clk_i.
*/
module wfi_spi_slave
  import wfi_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  output logic      miso_oe_o,
  wfi_reg_if.spi    bus
);
  import wfi_pkg::*;

  logic       sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic       cs_n_s1_reg, cs_n_s2_reg;
  logic       mosi_s1_reg, mosi_s2_reg;
  logic [4:0] bit_cnt_reg;
  logic [6:0] in_shift_reg;
  logic [7:0] out_shift_reg;
  logic       is_write_reg;
  logic       load_reg;
  logic       wr_stb_reg;
  logic [7:0] wdata_reg;
  logic [6:0] addr_reg;
  logic       active;
  logic       rise;
  logic       fall;

  // ==========================================================================
  // pin synchronisers; only the second stage and later are looked at
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_n_s1_reg <= 1'b1;
      cs_n_s2_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end
    else
    begin
      sclk_s1_reg <= sclk_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_n_s1_reg <= cs_n_i;
      cs_n_s2_reg <= cs_n_s1_reg;
      mosi_s1_reg <= mosi_i;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  assign active = ~cs_n_s2_reg;
  assign rise   = active & sclk_s2_reg & ~sclk_s3_reg;
  assign fall   = active & ~sclk_s2_reg & sclk_s3_reg;

  // ==========================================================================
  // bit counter and input shifter; deselect aborts a short frame
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !active)
    begin
      bit_cnt_reg  <= 5'h00;
      in_shift_reg <= 7'h00;
    end
    else if (rise)
    begin
      bit_cnt_reg  <= bit_cnt_reg + 5'h01;
      in_shift_reg <= {in_shift_reg[5:0], mosi_s2_reg};
    end
  end

  // ==========================================================================
  // address capture after the eighth bit, read data loaded one cycle later
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      addr_reg     <= 7'h00;
      is_write_reg <= 1'b0;
      load_reg     <= 1'b0;
    end
    else
    begin
      load_reg <= rise && (bit_cnt_reg == WFI_ADDR_DONE_CNT);
      if (rise && (bit_cnt_reg == WFI_ADDR_DONE_CNT))
      begin
        addr_reg     <= in_shift_reg;
        is_write_reg <= mosi_s2_reg;
      end
    end
  end

  // ==========================================================================
  // output shifter, advanced on falling edges of the data byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      out_shift_reg <= 8'h00;
    else if (load_reg)
      out_shift_reg <= bus.rdata;
    else if (fall && (bit_cnt_reg >= WFI_OUT_FIRST_CNT))
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
  end

  // ==========================================================================
  // write strobe on the sixteenth rising edge of a write frame
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_stb_reg <= 1'b0;
      wdata_reg  <= 8'h00;
    end
    else
    begin
      wr_stb_reg <= rise && (bit_cnt_reg == WFI_FRAME_LAST) && is_write_reg;
      if (rise && (bit_cnt_reg == WFI_FRAME_LAST))
        wdata_reg <= {in_shift_reg, mosi_s2_reg};
    end
  end

  assign bus.addr   = addr_reg;
  assign bus.wr_stb = wr_stb_reg;
  assign bus.wdata  = wdata_reg;
  assign miso_o     = out_shift_reg[7];
  assign miso_oe_o  = active;  // pin released while deselected

endmodule

/* wfi_wake_id_regs.sv */
/*
  Wake frame identifier filter register bank with its serial slave and the
  identifier matcher. Assumes a single 25 MHz clock with synchronous reset,
  a host driving the serial pins, and a frame decoder on the same clock
  presenting each received identifier for one cycle.
*/
// Summary of operation
// - Bit 5 of the third identifier register picks standard 11-bit (0) or extended 29-bit (1) frames.
// - Offset 30h holds extended identifier bits 17 to 10 as a full read-write byte.
// - Offset 31h holds extended identifier bits 9 to 2 as a full read-write byte.
// - Bits 7-6 at offset 32h hold extended identifier bits 1 and 0, read-write.
// - Bits 4-0 at offset 32h hold standard bits 10 to 6 or extended bits 28 to 24.
// - Bits 7-2 at offset 33h hold standard bits 5 to 0 or extended bits 23 to 18; bits 1-0 read zero.
// - Bits 1-0 at offset 34h hold extended mask bits 17 and 16; bits 7-2 read zero.
// - Offset 35h holds extended mask bits 15 to 8 as a full read-write byte.
// - Offset 36h holds extended mask bits 7 to 0 as a full read-write byte.
// - Offset 37h holds standard mask bits 10 to 3 or extended mask bits 28 to 21.
// - Every identifier and mask register leaves reset as zero in all bits.
// - Bits 7-5 at offset 38h hold standard mask bits 2 to 0 or extended mask bits 20 to 18.
module wfi_wake_id_regs
  import wfi_pkg::*;
#(
  parameter bit MASK_DONT_CARE = 1'b1
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic        frame_valid_i,
  input  wire logic        frame_ext_i,
  input  wire logic [28:0] frame_id_i,
  output logic             id_match_o,
  output logic             ident_format_select_o
);
  import wfi_pkg::*;

  // ==========================================================================
  // stored fields
  logic [7:0] ext_ident_bits_17_10_reg;
  logic [7:0] ext_ident_bits_9_2_reg;
  logic [1:0] ext_ident_bits_1_0_reg;
  logic       ident_format_select_reg;
  logic [4:0] base_ident_upper_reg;
  logic [5:0] base_ident_lower_reg;
  logic [1:0] ext_mask_bits_17_16_reg;
  logic [7:0] ext_mask_bits_15_8_reg;
  logic [7:0] ext_mask_bits_7_0_reg;
  logic [7:0] base_mask_upper_reg;
  logic [2:0] base_mask_lower_reg;
  logic [7:0] rdata_next;

  wfi_reg_if bus ();

  // ==========================================================================
  // serial register access from the host
  wfi_spi_slave u_spi
  (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .sclk_i    (spi_sclk_i),
    .cs_n_i    (spi_cs_n_i),
    .mosi_i    (spi_mosi_i),
    .miso_o    (spi_miso_o),
    .miso_oe_o (spi_miso_oe_o),
    .bus       (bus.spi)
  );

  // ==========================================================================
  // offset 30h: extended identifier high byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ext_ident_bits_17_10_reg <= WFI_RESET_BYTE;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_EXT_ID_HIGH))
      ext_ident_bits_17_10_reg <= bus.wdata;
  end

  // ==========================================================================
  // offset 31h: extended identifier middle byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ext_ident_bits_9_2_reg <= WFI_RESET_BYTE;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_EXT_ID_MID))
      ext_ident_bits_9_2_reg <= bus.wdata;
  end

  // ==========================================================================
  // offset 32h: low extended bits, format select and top base identifier bits
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      ext_ident_bits_1_0_reg  <= 2'b00;
      ident_format_select_reg <= 1'b0;
      base_ident_upper_reg    <= 5'h00;
    end
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_ID_FORMAT_TOP))
    begin
      ext_ident_bits_1_0_reg  <= bus.wdata[WFI_EXT_IDENT_BITS_1_0_LSB +: 2];
      ident_format_select_reg <= bus.wdata[WFI_FMT_BIT];
      base_ident_upper_reg    <= bus.wdata[4:0];
    end
  end

  // ==========================================================================
  // offset 33h: lower base identifier bits; bits 1-0 are not stored
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      base_ident_lower_reg <= 6'h00;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_BASE_ID_LOW))
      base_ident_lower_reg <= bus.wdata[WFI_BASE_LOWER_LSB +: 6];
  end

  // ==========================================================================
  // offset 34h: top two extended mask bits; upper bits are not stored
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ext_mask_bits_17_16_reg <= 2'b00;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_EXT_MASK_TOP))
      ext_mask_bits_17_16_reg <= bus.wdata[1:0];
  end

  // ==========================================================================
  // offset 35h: extended mask middle byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ext_mask_bits_15_8_reg <= WFI_RESET_BYTE;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_EXT_MASK_MID))
      ext_mask_bits_15_8_reg <= bus.wdata;
  end

  // ==========================================================================
  // offset 36h: extended mask low byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ext_mask_bits_7_0_reg <= WFI_RESET_BYTE;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_EXT_MASK_LOW))
      ext_mask_bits_7_0_reg <= bus.wdata;
  end

  // ==========================================================================
  // offset 37h: base mask upper byte
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      base_mask_upper_reg <= WFI_RESET_BYTE;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_BASE_MASK_HIGH))
      base_mask_upper_reg <= bus.wdata;
  end

  // ==========================================================================
  // offset 38h: only the base mask tail lives here; the length and data-mask
  // fields of that register are not stored anywhere and read zero
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      base_mask_lower_reg <= 3'b000;
    else if (bus.wr_stb && (bus.addr == WFI_ADDR_W_BASE_MASK_DLC))
      base_mask_lower_reg <= bus.wdata[WFI_BASE_MASK_L_LSB +: 3];
  end

  // ==========================================================================
  // read back; reserved bits and unmapped offsets read zero
  always_comb
  begin
    rdata_next = WFI_READ_ZERO;
    unique case (bus.addr)
      WFI_ADDR_W_EXT_ID_HIGH:
        rdata_next = ext_ident_bits_17_10_reg;
      WFI_ADDR_W_EXT_ID_MID:
        rdata_next = ext_ident_bits_9_2_reg;
      WFI_ADDR_W_ID_FORMAT_TOP:
        rdata_next = {ext_ident_bits_1_0_reg, ident_format_select_reg, base_ident_upper_reg};
      WFI_ADDR_W_BASE_ID_LOW:
        rdata_next = {base_ident_lower_reg, 2'b00};
      WFI_ADDR_W_EXT_MASK_TOP:
        rdata_next = {6'h00, ext_mask_bits_17_16_reg};
      WFI_ADDR_W_EXT_MASK_MID:
        rdata_next = ext_mask_bits_15_8_reg;
      WFI_ADDR_W_EXT_MASK_LOW:
        rdata_next = ext_mask_bits_7_0_reg;
      WFI_ADDR_W_BASE_MASK_HIGH:
        rdata_next = base_mask_upper_reg;
      WFI_ADDR_W_BASE_MASK_DLC:
        rdata_next = {base_mask_lower_reg, 5'h00};
      default:
        rdata_next = WFI_READ_ZERO;
    endcase
  end

  assign bus.rdata = rdata_next;

  // ==========================================================================
  // assembled 29-bit identifier and mask; the base fields always sit on top,
  // so a standard identifier is simply the upper eleven bits
  assign bus.ident = {base_ident_upper_reg, base_ident_lower_reg,
                      ext_ident_bits_17_10_reg, ext_ident_bits_9_2_reg,
                      ext_ident_bits_1_0_reg};
  assign bus.mask  = {base_mask_upper_reg, base_mask_lower_reg,
                      ext_mask_bits_17_16_reg, ext_mask_bits_15_8_reg,
                      ext_mask_bits_7_0_reg};
  assign bus.ext_sel = ident_format_select_reg;

  // ==========================================================================
  // frame identifier compare
  wfi_id_matcher #(
    .MASK_DONT_CARE (MASK_DONT_CARE)
  ) u_match
  (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .frame_valid_i (frame_valid_i),
    .frame_ext_i   (frame_ext_i),
    .frame_id_i    (frame_id_i),
    .match_o       (id_match_o),
    .cfg           (bus.match)
  );

  assign ident_format_select_o = ident_format_select_reg;

endmodule

/* wfi_wake_id_regs_chk.sv */
/*
  Checker for the wake identifier bank: match pulse timing, format select
  output and serial output enable, seen at the top module's ports.
  Assumes one clock and a synchronous active-high reset.
*/
module wfi_wake_id_regs_chk
(
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic spi_cs_n_i,
  input  wire logic spi_miso_oe_o,
  input  wire logic frame_valid_i,
  input  wire logic frame_ext_i,
  input  wire logic id_match_o,
  input  wire logic ident_format_select_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================
  // helper logic
  logic [4:0] idle_cnt_reg;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // cycles since chip select was last low; saturates so long idles never wrap
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !spi_cs_n_i)
      idle_cnt_reg <= 5'h00;
    else if (idle_cnt_reg != 5'h1F)
      idle_cnt_reg <= idle_cnt_reg + 5'h01;
  end

  // ==========================
  // assertions
  a_match_after_valid : assert property (id_match_o |-> $past(frame_valid_i))
    else $error("match pulse without a frame one cycle earlier");
  a_match_format : assert property (id_match_o |-> ($past(frame_ext_i) == $past(ident_format_select_o)))
    else $error("match on a frame of the other format");
  a_match_single : assert property ((id_match_o && !frame_valid_i) |=> !id_match_o)
    else $error("match pulse longer than one cycle");
  a_reset_clears : assert property ($fell(sys_rst_i) |-> !ident_format_select_o && !id_match_o)
    else $error("outputs not cleared by reset");
  a_fmt_after_frame : assert property ($changed(ident_format_select_o) |-> idle_cnt_reg < 5'h10)
    else $error("format select moved with no serial frame");
  a_fmt_quiet : assert property (spi_cs_n_i [*8] |=> $stable(ident_format_select_o))
    else $error("format select moved while deselected");
  a_oe_cs_low : assert property (!spi_cs_n_i [*5] |-> spi_miso_oe_o)
    else $error("serial output not enabled while selected");
  a_oe_cs_high : assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
    else $error("serial output enabled while deselected");
endmodule

bind wfi_wake_id_regs wfi_wake_id_regs_chk u_chk
(
  .ref_clk_i             (ref_clk_i),
  .sys_rst_i             (sys_rst_i),
  .spi_cs_n_i            (spi_cs_n_i),
  .spi_miso_oe_o         (spi_miso_oe_o),
  .frame_valid_i         (frame_valid_i),
  .frame_ext_i           (frame_ext_i),
  .id_match_o            (id_match_o),
  .ident_format_select_o (ident_format_select_o)
);
